// ==== rtl/cpic_pkg.sv ====
// Package of constants and carrier types for the clock and power initial configuration block.
package cpic_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CLK_SRC    = 8'h00;
  localparam logic [7:0] ADDR_FAST_FREQ  = 8'h04;
  localparam logic [7:0] ADDR_POWER_MODE = 8'h08;
  localparam logic [7:0] ADDR_FLASH_WAIT = 8'h0C;
  localparam logic [7:0] ADDR_SUB_DRIVE  = 8'h10;
  localparam logic [7:0] ADDR_OSC_EN     = 8'h14;
  localparam logic [7:0] ADDR_MOD_STOP   = 8'h18;
  localparam logic [7:0] ADDR_PIN_PKG    = 8'h1C;
  localparam logic [7:0] ADDR_DIV_WORD   = 8'h20;
  localparam logic [7:0] ADDR_STATUS     = 8'h24;
  localparam logic [7:0] ADDR_WAIT_TMR   = 8'h28;
  localparam logic [7:0] ADDR_PDIR_BASE  = 8'h40;
  localparam int         NUM_PORTS       = 18;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [15:0] SRC_CODE_FAST_ONCHIP_OSC = 16'h0100;
  localparam logic [15:0] SRC_CODE_MAIN            = 16'h0200;
  localparam logic [15:0] SRC_CODE_SUB             = 16'h0300;
  localparam logic [15:0] SRC_CODE_PLL             = 16'h0400;
  localparam logic [7:0]  FAST_OSC_FREQ_SEL_LO     = 8'h00;
  localparam logic [7:0]  FAST_OSC_FREQ_SEL_MID    = 8'h01;
  localparam logic [7:0]  FAST_OSC_FREQ_SEL_HI     = 8'h02;
  localparam logic [7:0]  POWER_MODE_FAST          = 8'h00;
  localparam logic [7:0]  POWER_MODE_SLOW_ONE      = 8'h06;
  localparam logic [7:0]  POWER_MODE_SLOW_TWO      = 8'h07;
  localparam logic        FLASH_NO_WAIT            = 1'b0;
  localparam logic        FLASH_ONE_WAIT           = 1'b1;
  localparam logic [7:0]  SUB_OSC_DRIVE_LOW        = 8'h02;
  localparam logic [7:0]  SUB_OSC_DRIVE_STANDARD   = 8'h0C;
  localparam logic [31:0] DIV_WORD_PLL             = 32'h20C2_1222;
  localparam logic [31:0] DIV_WORD_FAST_OSC        = 32'h10C1_0111;
  localparam logic [31:0] DIV_WORD_OTHER           = 32'h55C5_5555;
  localparam logic        MODULE_STOP_ENABLE       = 1'b1;
  localparam logic        MODULE_STOP_DISABLE      = 1'b0;
  localparam logic [7:0]  PKG_176                  = 8'h00;
  localparam logic [7:0]  PKG_144                  = 8'h01;
  localparam logic [7:0]  PKG_100                  = 8'h02;

  // ------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------
  localparam logic [15:0] RST_CLK_SRC    = SRC_CODE_PLL;
  localparam logic [7:0]  RST_FAST_FREQ  = FAST_OSC_FREQ_SEL_HI;
  localparam logic [7:0]  RST_POWER_MODE = POWER_MODE_FAST;
  localparam logic        RST_FLASH_WAIT = FLASH_ONE_WAIT;
  localparam logic [7:0]  RST_SUB_DRIVE  = SUB_OSC_DRIVE_LOW;
  localparam logic [4:0]  RST_MOD_STOP   = 5'h00;
  localparam int          OSC_PLL_BIT    = 0;
  localparam int          OSC_FAST_BIT   = 1;
  localparam int          OSC_SUBSYS_BIT = 2;
  localparam int          OSC_SUBRTC_BIT = 3;
  localparam int          ST_SUB_ON_BIT  = 0;
  localparam int          ST_REJECT_BIT  = 1;

  // ------------------------------------------------------------
  // Wait timer: period 121212 ns at 200 MHz
  // ------------------------------------------------------------
  localparam int          SYS_CLK_PERIOD_PS = 5000;
  localparam longint      WAIT_TICK_NS      = 121212;
  localparam int          WAIT_TICK_CYC     = int'((WAIT_TICK_NS * 1000) / SYS_CLK_PERIOD_PS);

  // Direction masks per package, ports 0-9, A-G, J.
  typedef logic [NUM_PORTS*8-1:0] cpic_mask_vec_t;
  localparam cpic_mask_vec_t MASK_176 = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                         8'h00, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam cpic_mask_vec_t MASK_144 = {8'h00, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0,
                                         8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  localparam cpic_mask_vec_t MASK_100 = {8'h20, 8'hFF, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
                                         8'hCF, 8'hFF, 8'hFF, 8'h40, 8'h00, 8'h00, 8'h00, 8'h03, 8'h0F};

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] clk_src;
    logic [7:0]  fast_freq;
    logic [7:0]  power_mode;
    logic        flash_wait;
    logic [7:0]  sub_drive;
    logic        pll_en;
    logic        fast_osc_en;
    logic        sub_osc_en;
  } cpic_clk_cfg_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } cpic_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } cpic_axi_rsp_t;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== rtl/cpic_top.sv ====
// Clock and power start-up configuration block with an AXI4-Lite register slave.
`timescale 1ns/1ps
module cpic_top
  import cpic_pkg::*;
(
  // Clock and reset.
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // AXI4-Lite slave.
  input  wire cpic_axi_req_t          axi_req,
  output cpic_axi_rsp_t               axi_rsp,
  // Configuration toward oscillators and flash.
  output cpic_clk_cfg_t               clk_cfg,
  output logic [31:0]                 clock_divider_word,
  output logic [4:0]                  module_stop,
  // Direction registers of the ports, one byte per port.
  output logic [NUM_PORTS*8-1:0]      port_direction_reg
);

  logic [15:0]          clk_src;
  logic [7:0]           fast_freq;
  logic [7:0]           power_mode;
  logic                 flash_wait;
  logic [7:0]           sub_drive;
  logic [3:0]           osc_en;
  logic [4:0]           mod_stop;
  logic [7:0]           pin_pkg;
  logic [31:0]          div_word;
  logic                 reject_flag;
  logic [NUM_PORTS*8-1:0] pdir;
  logic                 tmr_run;
  logic                 tmr_clear;
  logic [15:0]          tmr_ticks;
  logic                 aw_held;
  logic                 w_held;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 do_write;
  logic                 wr_ok;
  logic                 wr_illegal;
  logic [31:0]          next_rdata;
  logic                 rd_hit;
  cpic_mask_vec_t       pkg_mask;
  logic                 pkg_write;

  // ------------------------------------------------------------
  // Write channel capture
  // ------------------------------------------------------------
  // Address and data are accepted independently, in any order.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_held <= 1'b1;
        aw_addr <= axi_req.awaddr[7:0];
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_held <= 1'b1;
        w_data <= axi_req.wdata;
        w_strb <= axi_req.wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  assign do_write = aw_held && w_held && !axi_rsp.bvalid;

  // Decode: illegal codes are reported but never stored.
  always_comb begin
    wr_ok      = 1'b1;
    wr_illegal = 1'b0;
    if (aw_addr >= ADDR_PDIR_BASE && aw_addr < ADDR_PDIR_BASE + 8'(NUM_PORTS * 4) && aw_addr[1:0] == 2'b00) begin
      wr_ok = 1'b1;
    end else begin
      unique case (aw_addr)
        ADDR_CLK_SRC: begin
          wr_illegal = !(w_data[15:0] == SRC_CODE_FAST_ONCHIP_OSC || w_data[15:0] == SRC_CODE_MAIN ||
                         w_data[15:0] == SRC_CODE_SUB || w_data[15:0] == SRC_CODE_PLL);
        end
        ADDR_FAST_FREQ: begin
          wr_illegal = !(w_data[7:0] == FAST_OSC_FREQ_SEL_LO || w_data[7:0] == FAST_OSC_FREQ_SEL_MID ||
                         w_data[7:0] == FAST_OSC_FREQ_SEL_HI);
        end
        ADDR_POWER_MODE: begin
          wr_illegal = !(w_data[7:0] == POWER_MODE_FAST || w_data[7:0] == POWER_MODE_SLOW_ONE ||
                         w_data[7:0] == POWER_MODE_SLOW_TWO);
        end
        ADDR_SUB_DRIVE: begin
          wr_illegal = !(w_data[7:0] == SUB_OSC_DRIVE_LOW || w_data[7:0] == SUB_OSC_DRIVE_STANDARD);
        end
        ADDR_FLASH_WAIT, ADDR_OSC_EN, ADDR_MOD_STOP, ADDR_PIN_PKG, ADDR_DIV_WORD, ADDR_STATUS,
        ADDR_WAIT_TMR: begin
          wr_illegal = 1'b0;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Stores happen only when the low-byte strobe w_strb[0] is set so a stray upper-lane write cannot corrupt a code.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_src    <= RST_CLK_SRC;
      fast_freq  <= RST_FAST_FREQ;
      power_mode <= RST_POWER_MODE;
      flash_wait <= RST_FLASH_WAIT;
      sub_drive  <= RST_SUB_DRIVE;
      osc_en     <= 4'h0;
      mod_stop   <= RST_MOD_STOP;
      pin_pkg    <= PKG_176;
      div_word   <= DIV_WORD_PLL;
      tmr_run    <= 1'b0;
    end else if (do_write && wr_ok && !wr_illegal && w_strb[0]) begin
      unique case (aw_addr)
        ADDR_CLK_SRC:    clk_src    <= w_data[15:0];
        ADDR_FAST_FREQ:  fast_freq  <= w_data[7:0];
        ADDR_POWER_MODE: power_mode <= w_data[7:0];
        ADDR_FLASH_WAIT: flash_wait <= w_data[0];
        ADDR_SUB_DRIVE:  sub_drive  <= w_data[7:0];
        ADDR_OSC_EN:     osc_en     <= w_data[3:0];
        ADDR_MOD_STOP:   mod_stop   <= w_data[4:0];
        ADDR_PIN_PKG:    pin_pkg    <= w_data[7:0];
        ADDR_DIV_WORD:   div_word   <= w_data;
        ADDR_WAIT_TMR:   tmr_run    <= w_data[0];
        default: begin
        end
      endcase
    end
  end

  // Sticky reject flag; a new rejection wins over a clear in the same write cycle.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reject_flag <= 1'b0;
    end else if (do_write && wr_ok && wr_illegal) begin
      reject_flag <= 1'b1;
    end else if (do_write && aw_addr == ADDR_STATUS && w_data[ST_REJECT_BIT]) begin
      reject_flag <= 1'b0;
    end
  end

  assign tmr_clear = do_write && aw_addr == ADDR_WAIT_TMR && w_data[1];
  assign pkg_write = do_write && w_strb[0] && aw_addr == ADDR_PIN_PKG;

  // ------------------------------------------------------------
  // Port direction masks
  // ------------------------------------------------------------
  // A package write selects its own masks at once, so the default package cannot leave bits behind.
  always_comb begin
    unique case (pkg_write ? w_data[7:0] : pin_pkg)
      PKG_144: pkg_mask = MASK_144;
      PKG_100: pkg_mask = MASK_100;
      default: pkg_mask = MASK_176;
    endcase
  end

  // Missing pins are forced to output so they cannot float; user writes only touch present pins.
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          pdir[gp*8 +: 8] <= 8'h00;
        end else if (pkg_write) begin
          pdir[gp*8 +: 8] <= pkg_mask[gp*8 +: 8];
        end else if (do_write && w_strb[0] && aw_addr == ADDR_PDIR_BASE + 8'(gp * 4)) begin
          pdir[gp*8 +: 8] <= w_data[7:0] | pkg_mask[gp*8 +: 8];
        end else begin
          pdir[gp*8 +: 8] <= pdir[gp*8 +: 8] | pkg_mask[gp*8 +: 8];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_cfg            <= '0;
      clock_divider_word <= DIV_WORD_PLL;
      module_stop        <= RST_MOD_STOP;
      port_direction_reg <= '0;
    end else begin
      clk_cfg.clk_src     <= clk_src;
      clk_cfg.fast_freq   <= fast_freq;
      clk_cfg.power_mode  <= power_mode;
      clk_cfg.flash_wait  <= flash_wait;
      clk_cfg.sub_drive   <= sub_drive;
      clk_cfg.pll_en      <= osc_en[OSC_PLL_BIT];
      clk_cfg.fast_osc_en <= osc_en[OSC_FAST_BIT];
      clk_cfg.sub_osc_en  <= osc_en[OSC_SUBSYS_BIT] | osc_en[OSC_SUBRTC_BIT];
      clock_divider_word  <= div_word;
      module_stop         <= mod_stop;
      port_direction_reg  <= pdir;
    end
  end

  cpic_wait_timer u_wait_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run     (tmr_run),
    .clear   (tmr_clear),
    .ticks   (tmr_ticks)
  );

  // ------------------------------------------------------------
  // Bus handshake and read path
  // ------------------------------------------------------------
  always_comb begin
    rd_hit     = 1'b1;
    next_rdata = 32'h0000_0000;
    if (axi_req.araddr[7:0] >= ADDR_PDIR_BASE && axi_req.araddr[7:0] < ADDR_PDIR_BASE + 8'(NUM_PORTS * 4)) begin
      next_rdata[7:0] = pdir[8'(axi_req.araddr[7:2] - ADDR_PDIR_BASE[7:2]) * 8 +: 8];
    end else begin
      unique case (axi_req.araddr[7:0])
        ADDR_CLK_SRC:    next_rdata[15:0] = clk_src;
        ADDR_FAST_FREQ:  next_rdata[7:0]  = fast_freq;
        ADDR_POWER_MODE: next_rdata[7:0]  = power_mode;
        ADDR_FLASH_WAIT: next_rdata[0]    = flash_wait;
        ADDR_SUB_DRIVE:  next_rdata[7:0]  = sub_drive;
        ADDR_OSC_EN:     next_rdata[3:0]  = osc_en;
        ADDR_MOD_STOP:   next_rdata[4:0]  = mod_stop;
        ADDR_PIN_PKG:    next_rdata[7:0]  = pin_pkg;
        ADDR_DIV_WORD:   next_rdata       = div_word;
        ADDR_STATUS: begin
          next_rdata[ST_SUB_ON_BIT] = clk_cfg.sub_osc_en;
          next_rdata[ST_REJECT_BIT] = reject_flag;
        end
        ADDR_WAIT_TMR:   next_rdata       = {tmr_ticks, 15'h0000, tmr_run};
        default:         rd_hit           = 1'b0;
      endcase
    end
  end

  // One write and one read at a time; answers come one cycle after both halves are held.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      axi_rsp <= '0;
    end else begin
      axi_rsp.awready <= !aw_held && !(axi_req.awvalid && axi_rsp.awready) && !axi_rsp.bvalid;
      axi_rsp.wready  <= !w_held && !(axi_req.wvalid && axi_rsp.wready) && !axi_rsp.bvalid;
      if (do_write) begin
        axi_rsp.bvalid <= 1'b1;
        axi_rsp.bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req.bready) begin
        axi_rsp.bvalid <= 1'b0;
      end
      axi_rsp.arready <= 1'b0;
      if (axi_req.arvalid && !axi_rsp.arready && !axi_rsp.rvalid) begin
        axi_rsp.arready <= 1'b1;
        axi_rsp.rvalid  <= 1'b1;
        axi_rsp.rdata   <= next_rdata;
        axi_rsp.rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_rsp.rvalid && axi_req.rready) begin
        axi_rsp.rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== rtl/cpic_wait_timer.sv ====
// Software wait timer ticking once every 121212 ns.
`timescale 1ns/1ps
module cpic_wait_timer
  import cpic_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Control.
  input  wire logic        run,
  input  wire logic        clear,
  // Count of elapsed ticks.
  output logic [15:0]      ticks
);

  logic [15:0] prescale;
  logic        tick_en;

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  // One-cycle enable every tick period; the period is fixed by the slow oscillator limit.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= 16'h0000;
    end else if (clear || !run || tick_en) begin
      prescale <= 16'h0000;
    end else begin
      prescale <= prescale + 16'h0001;
    end
  end
  assign tick_en = run && (prescale == 16'(WAIT_TICK_CYC - 1));

  // Tick counter, wraps silently.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ticks <= 16'h0000;
    end else if (clear) begin
      ticks <= 16'h0000;
    end else if (tick_en) begin
      ticks <= ticks + 16'h0001;
    end
  end

endmodule

// ==== test/cpic_chk.sv ====
// Port checker of the clock and power configuration block.
`timescale 1ns/1ps
module cpic_chk
  import cpic_pkg::*;
(
  // Clock and reset.
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Watched ports.
  input  wire cpic_axi_req_t          axi_req,
  input  wire cpic_axi_rsp_t          axi_rsp,
  input  wire cpic_clk_cfg_t          clk_cfg,
  input  wire logic [31:0]            clock_divider_word,
  input  wire logic [4:0]             module_stop,
  input  wire logic [NUM_PORTS*8-1:0] port_direction_reg
);
  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Both halves of a write taken at one edge, then the answer.
  sequence wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence wr_answer;
    ##[1:2] axi_rsp.bvalid;
  endsequence

  wr_resp_a: assert property (wr_taken |-> wr_answer) else $error("Write response missing.");
  bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("Write response dropped early.");
  rd_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("Read data dropped early.");
  ar_pulse_a: assert property (axi_rsp.arready |=> !axi_rsp.arready) else $error("Read address ready not a pulse.");
  rd_answer_a: assert property (axi_rsp.arready |-> axi_rsp.rvalid) else $error("Read data not with address.");
  aw_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("New write taken before response.");

  // ----------------------------------------
  // Configuration codes
  // ----------------------------------------
  // Outputs lag the registers by one edge, so the first edge after reset is skipped.
  src_code_a: assert property ($past(rst_b) |-> clk_cfg.clk_src inside {16'h0100,16'h0200,16'h0300,16'h0400})
    else $error("Clock source code illegal.");
  freq_code_a: assert property ($past(rst_b) |-> clk_cfg.fast_freq inside {8'h00, 8'h01, 8'h02})
    else $error("Oscillator frequency code illegal.");
  mode_code_a: assert property ($past(rst_b) |-> clk_cfg.power_mode inside {8'h00, 8'h06, 8'h07})
    else $error("Power mode code illegal.");
  drive_code_a: assert property ($past(rst_b) |-> clk_cfg.sub_drive inside {8'h02, 8'h0C})
    else $error("Sub drive code illegal.");
endmodule

bind cpic_top cpic_chk u_cpic_chk (.sys_clk(sys_clk), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .clk_cfg(clk_cfg), .clock_divider_word(clock_divider_word), .module_stop(module_stop),
  .port_direction_reg(port_direction_reg));

// ==== test/cpic_top_tb_top.sv ====
// Self-checking testbench of the clock and power configuration block.
`timescale 1ns/1ps
module cpic_top_tb_top
  import cpic_pkg::*;
;
  logic                   sys_clk   = 1'b0;
  logic                   rst_b     = 1'b0;
  cpic_axi_req_t          req       = '0;
  cpic_axi_rsp_t          rsp;
  cpic_clk_cfg_t          cfg;
  logic [31:0]            div;
  logic [4:0]             mstop;
  logic [NUM_PORTS*8-1:0] pdir;
  logic [31:0]            rdv;
  logic [1:0]             rsv;
  int                     bad_count = 0;
  int                     tests_run = 0;

  cpic_top u_cpic_top (.sys_clk(sys_clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp), .clk_cfg(cfg),
    .clock_divider_word(div), .module_stop(mstop), .port_direction_reg(pdir));

  // Five nanosecond clock.
  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Each channel is released only at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.awaddr  <= {24'h0, a};
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    rsv = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    req.araddr  <= {24'h0, a};
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    rdv = rsp.rdata;
    rsv = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Two spare edges let the one-edge output lag settle.
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    chk(32'(rsv), 32'(RESP_OKAY), "write response");
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask

  function automatic logic [31:0] cfg_of(input logic [7:0] a);
    case (a)
      ADDR_CLK_SRC:    return 32'(cfg.clk_src);
      ADDR_FAST_FREQ:  return 32'(cfg.fast_freq);
      ADDR_POWER_MODE: return 32'(cfg.power_mode);
      default:         return 32'(cfg.sub_drive);
    endcase
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(32'(cfg.clk_src), 32'h0400, "source at reset");
    chk(32'(cfg.flash_wait), 32'h1, "flash wait at reset");
    chk(div, 32'h20C2_1222, "divider at reset");
    chk(32'(mstop), 32'h0, "module stop at reset");
    $display("t_reset done");
  endtask

  // Every listed code is stored and driven out; an unlisted one is dropped and flagged.
  task automatic t_codes(input logic [7:0] a, input logic [15:0] c [4], input int n, input logic [15:0] ill);
    for (int i = 0; i < n; i++) begin
      wok(a, 32'(c[i]));
      rd(a);
      chk(rdv, 32'(c[i]), "code readback");
      chk(cfg_of(a), 32'(c[i]), "code output");
    end
    wok(a, 32'(ill));
    rd(a);
    chk(rdv, 32'(c[n-1]), "illegal code kept");
    rd(ADDR_STATUS);
    chk(32'(rdv[1]), 32'h1, "reject flag set");
    wok(ADDR_STATUS, 32'h2);
    rd(ADDR_STATUS);
    chk(32'(rdv[1]), 32'h0, "reject flag cleared");
    $display("t_codes at %h done", a);
  endtask

  // Sub oscillator runs for either use; the other enables pass through.
  task automatic t_osc();
    logic [3:0] e [5];
    e = '{4'h3, 4'h4, 4'h8, 4'hC, 4'h0};
    for (int i = 0; i < 5; i++) begin
      wok(ADDR_OSC_EN, 32'(e[i]));
      rd(ADDR_STATUS);
      chk(32'(rdv[0]), 32'(e[i][3:2] != 2'b00), "sub oscillator status");
      chk(32'(cfg.sub_osc_en), 32'(e[i][3:2] != 2'b00), "sub oscillator enable");
      chk(32'({cfg.fast_osc_en, cfg.pll_en}), 32'(e[i][1:0]), "fast and loop enables");
    end
    $display("t_osc done");
  endtask

  task automatic t_misc();
    for (int i = 0; i < 2; i++) begin
      wok(ADDR_FLASH_WAIT, 32'(i));
      chk(32'(cfg.flash_wait), 32'(i), "flash wait");
    end
    wok(ADDR_MOD_STOP, 32'h15);
    chk(32'(mstop), 32'h15, "module stop set");
    wok(ADDR_MOD_STOP, 32'h0);
    chk(32'(mstop), 32'h0, "module stop cleared");
    wok(ADDR_DIV_WORD, 32'h10C1_0111);
    chk(div, 32'h10C1_0111, "divider word");
    wr(8'h30, 32'h1);
    chk(32'(rsv), 32'(RESP_SLVERR), "unmapped write");
    rd(8'h30);
    chk(32'(rsv), 32'(RESP_SLVERR), "unmapped read");
    $display("t_misc done");
  endtask

  // One tick is 121212 ns; looked at just before the first tick and well inside the second period.
  task automatic t_timer();
    wok(ADDR_WAIT_TMR, 32'h1);
    repeat (24000) @(posedge sys_clk);
    rd(ADDR_WAIT_TMR);
    chk(32'(rdv[31:16]), 32'h0, "no tick before one period");
    repeat (6000) @(posedge sys_clk);
    rd(ADDR_WAIT_TMR);
    chk(32'(rdv[31:16]), 32'h1, "ticks after one period");
    wok(ADDR_WAIT_TMR, 32'h2);
    rd(ADDR_WAIT_TMR);
    chk(32'(rdv[31:16]), 32'h0, "ticks cleared");
    $display("t_timer done");
  endtask

  // Fresh reset per package so masks of an earlier package cannot linger.
  task automatic t_pkg();
    logic [NUM_PORTS*8-1:0] m [4];
    m[0] = 144'h70 << 40;
    m[1] = 144'h00FF_1F00_0000_0000_F000_0000_0000_0000_0300;
    m[2] = 144'h20FF_3F00_0000_0000_FFCF_FFFF_4000_0000_030F;
    m[3] = m[0];
    for (int p = 0; p < 4; p++) begin
      do_reset();
      wok(ADDR_PIN_PKG, 32'(p));
      tests_run++;
      if (pdir !== m[p]) begin
        bad_count++;
        $display("BAD %0t package %0d masks %h", $time, p, pdir);
      end
    end
    // Port 0 has missing pins only in the 100-pin package.
    wok(ADDR_PIN_PKG, 32'(PKG_100));
    wok(ADDR_PDIR_BASE, 32'h30);
    rd(ADDR_PDIR_BASE);
    chk(rdv, 32'h3F, "missing pins stay output");
    wok(ADDR_PDIR_BASE, 32'h0);
    chk(32'(pdir[7:0]), 32'h0F, "mask kept after clear");
    $display("t_pkg done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    do_reset();
    // The outputs take the register values at the first edge; look after the second.
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_codes(ADDR_CLK_SRC, '{16'h0400, 16'h0200, 16'h0300, 16'h0100}, 4, 16'h0500);
    t_codes(ADDR_FAST_FREQ, '{16'h00, 16'h01, 16'h02, 16'h0}, 3, 16'h03);
    t_codes(ADDR_SUB_DRIVE, '{16'h0C, 16'h02, 16'h0, 16'h0}, 2, 16'h03);
    t_osc();
    t_misc();
    // Core on the fast on-chip oscillator, so zero wait is allowed; oscillators off before the slow modes.
    wok(ADDR_FLASH_WAIT, 32'h0);
    t_codes(ADDR_POWER_MODE, '{16'h00, 16'h06, 16'h07, 16'h0}, 3, 16'h05);
    wok(ADDR_POWER_MODE, 32'h0);
    t_timer();
    t_pkg();
    stop_test();
  end

  // The run needs about 30500 cycles.
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end
endmodule
